// ### acs_pkg.sv
// shared constants and carrier types of the sample capture engine
package acs_pkg;

    // widths of the converter and memory side
    localparam int unsigned RES_W  = 12;
    localparam int unsigned ID_W   = 4;
    localparam int unsigned PTR_W  = 24;
    localparam int unsigned CAL_W  = 14;

    // register byte offsets on the bus
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_PTR_LOW   = 8'h04;
    localparam logic [7:0] REG_PTR_HIGH  = 8'h08;
    localparam logic [7:0] REG_PTR_PAGE  = 8'h0c;
    localparam logic [7:0] REG_OFS_HIGH  = 8'h10;
    localparam logic [7:0] REG_OFS_LOW   = 8'h14;
    localparam logic [7:0] REG_GAIN_HIGH = 8'h18;
    localparam logic [7:0] REG_GAIN_LOW  = 8'h1c;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h24;
    localparam logic [7:0] REG_STATE     = 8'h28;
    localparam logic [7:0] REG_RESULT    = 8'h2c;

    // field positions
    localparam int unsigned CTRL_EN_BIT = 6;
    localparam int unsigned IRQ_DONE    = 0;
    localparam int unsigned IRQ_CAL     = 1;
    localparam int unsigned IRQ_W       = 2;

    // sequencing constants
    localparam logic [3:0]  STOP_ID   = 4'hf;
    localparam logic [23:0] PTR_STEP  = 24'h000001;
    localparam logic [23:0] ID_STRIDE = 24'h000002;

    // calibration arithmetic: mid code is the neutral trim
    localparam logic [13:0] CAL_MID    = 14'h2000;
    localparam int          OFS_SHIFT  = 5;
    localparam int          GAIN_SHIFT = 18;
    localparam int          GAIN_SPAN  = 6553;
    localparam int          RES_MAX    = 4095;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } acs_mem_req_t;

    typedef struct packed {
        logic       start;
        logic [3:0] channel;
    } acs_conv_req_t;

    typedef struct packed {
        logic        done;
        logic [11:0] result;
    } acs_conv_rsp_t;

endpackage

// ### acs_cal_store.sv
// hidden trim store holding the factory offset and gain words
`timescale 1ns/1ns
`default_nettype none
module acs_cal_store #(
    parameter int unsigned DEPTH     = 2,
    parameter logic [13:0] OFS_INIT  = 14'h2000,  // arbitrary factory trim
    parameter logic [13:0] GAIN_INIT = 14'h2000   // arbitrary factory trim
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        rd_addr,
    output logic [13:0]      rd_data
);
    import acs_pkg::*;

    // word 0 is offset, word 1 is gain; nothing else fits the address
    if (DEPTH != 2) begin : g_bad_depth
        $error("acs_cal_store holds exactly two words");
    end

    typedef struct packed {
        logic [13:0] rdata;
    } acs_rom_state_t;

    acs_rom_state_t st;
    acs_rom_state_t next_st;

    // registered read, one cycle after the address
    always_comb begin
        next_st = st;
        next_st.rdata = rd_addr ? GAIN_INIT : OFS_INIT;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rdata;
endmodule
`default_nettype wire

// ### acs_capture.sv
// sample capture engine with calibration trim and bus slave
`timescale 1ns/1ns
`default_nettype none
// Function
// - engine steps per conversion period, overlapping conversion and memory traffic
// - each cycle converts the channel fetched in the previous cycle
// - each cycle writes previous 12-bit result with its channel id
// - each cycle fetches the id for the following cycle
// - first result reaches memory in the third capture cycle
// - core memory accesses are dropped while capture is enabled
// - interrupt raised when the capture ends at the stop code
// - offset and gain words, 14 bits, split six-high and eight-low
// - larger offset word pushes the result down
// - larger gain word steepens slope, span limited to 0.975..1.025
// - factory trim words copied into the registers after reset
// - control bit 6 enables capture
// - ids in top nibble of every second byte; repeat then 1111 stops
// - completion sets the done flag, last two locations left untouched
module acs_capture #(
    parameter logic [13:0] OFS_FACTORY  = 14'h2000,  // arbitrary factory trim
    parameter logic [13:0] GAIN_FACTORY = 14'h2000   // arbitrary factory trim
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    output acs_pkg::acs_conv_req_t      conv_req,
    input  wire acs_pkg::acs_conv_rsp_t conv_rsp,
    output acs_pkg::acs_mem_req_t       mem_req,
    input  wire logic [7:0]             mem_rdata,
    input  wire acs_pkg::acs_mem_req_t  core_req,
    output logic                        capture_active,
    output logic                        irq
);
    import acs_pkg::*;

    typedef enum logic [3:0] {
        PH_LOAD0, PH_LOAD1, PH_LOAD2, PH_IDLE, PH_START, PH_WR_HI,
        PH_WR_LO, PH_FETCH, PH_FETCH_LAT, PH_WAIT, PH_DONE
    } acs_phase_t;

    typedef struct packed {
        acs_phase_t     phase;
        logic           en;
        logic [23:0]    ptr;
        logic [13:0]    ofs;
        logic [13:0]    gain;
        logic [1:0]     irq_stat;
        logic [1:0]     irq_mask;
        logic [11:0]    last_res;
        logic [23:0]    wr_ptr;
        logic [23:0]    fetch_ptr;
        logic [3:0]     cur_id;
        logic [3:0]     next_id;
        logic [3:0]     last_id;
        logic           have_id;
        logic           next_valid;
        logic           seen_id;
        logic           repeat_id;
        logic           stop_seen;
        logic           have_res;
        logic           conv_busy;
        logic           conv_got;
        logic [11:0]    conv_val;
        logic [15:0]    res_pend;
        acs_conv_req_t  conv;
        acs_mem_req_t   mem;
        logic [31:0]    rdata;
        logic           wr_pend;
        logic [7:0]     wr_addr;
    } acs_state_t;

    acs_state_t  st;
    acs_state_t  next_st;
    logic        cal_addr;
    logic [13:0] cal_word;
    logic        busy;

    // signed offset removal, then gain scaling, then clamp to 12 bits
    function automatic logic [11:0] cal_apply(input logic [11:0] raw,
                                              input logic [13:0] ofs,
                                              input logic [13:0] gain);
        logic signed [31:0] x;
        logic signed [31:0] gd;
        logic signed [31:0] y;
        x  = $signed({20'h0, raw})
             - (($signed({18'h0, ofs}) - $signed({18'h0, CAL_MID})) >>> OFS_SHIFT);
        gd = $signed({18'h0, gain}) - $signed({18'h0, CAL_MID});
        // limit keeps the slope inside the permitted span
        if (gd > GAIN_SPAN) begin
            gd = GAIN_SPAN;
        end
        if (gd < -GAIN_SPAN) begin
            gd = -GAIN_SPAN;
        end
        y = x + ((x * gd) >>> GAIN_SHIFT);
        if (y < 0) begin
            cal_apply = 12'h000;
        end else if (y > RES_MAX) begin
            cal_apply = 12'hfff;
        end else begin
            cal_apply = y[11:0];
        end
    endfunction

    // replace one byte lane of the capture pointer
    function automatic logic [23:0] set_byte(input logic [23:0] p,
                                             input logic [1:0]  lane,
                                             input logic [7:0]  b);
        logic [23:0] r;
        r = p;
        case (lane)
            2'd0:    r[7:0]   = b;
            2'd1:    r[15:8]  = b;
            default: r[23:16] = b;
        endcase
        return r;
    endfunction

    acs_cal_store #(
        .DEPTH     (2),
        .OFS_INIT  (OFS_FACTORY),
        .GAIN_INIT (GAIN_FACTORY)
    ) u_cal_store (
        .core_clk (core_clk),
        .rst      (rst),
        .rd_addr  (cal_addr),
        .rd_data  (cal_word)
    );

    assign busy = (st.phase != PH_IDLE) && (st.phase != PH_DONE) && st.en;

    always_comb begin
        next_st = st;
        cal_addr = 1'b0;
        next_st.conv.start = 1'b0;

        // core traffic passes only while capture is off; address lines held
        if (st.en) begin
            next_st.mem = '0;
            next_st.mem.addr = st.mem.addr;
        end else begin
            next_st.mem = core_req;
        end

        // a conversion may finish in any phase, so hold it until consumed
        if (st.conv_busy && conv_rsp.done) begin
            next_st.conv_got = 1'b1;
            next_st.conv_val = cal_apply(conv_rsp.result, st.ofs, st.gain);
        end

        // data phase of a write accepted last cycle
        if (st.wr_pend) begin
            case (st.wr_addr)
                REG_CTRL:      next_st.en = hwdata[CTRL_EN_BIT];
                REG_PTR_LOW:   next_st.ptr = set_byte(st.ptr, 2'd0, hwdata[7:0]);
                REG_PTR_HIGH:  next_st.ptr = set_byte(st.ptr, 2'd1, hwdata[7:0]);
                REG_PTR_PAGE:  next_st.ptr = set_byte(st.ptr, 2'd2, hwdata[7:0]);
                REG_OFS_HIGH:  next_st.ofs[13:8] = hwdata[5:0];
                REG_OFS_LOW:   next_st.ofs[7:0] = hwdata[7:0];
                REG_GAIN_HIGH: next_st.gain[13:8] = hwdata[5:0];
                REG_GAIN_LOW:  next_st.gain[7:0] = hwdata[7:0];
                REG_IRQ_STAT:  next_st.irq_stat = st.irq_stat & ~hwdata[IRQ_W-1:0];
                REG_IRQ_MASK:  next_st.irq_mask = hwdata[IRQ_W-1:0];
                default:       next_st.wr_pend = 1'b0;
            endcase
        end

        // address phase; zero wait states so hready is always ours
        next_st.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr[7:0];
            next_st.rdata = '0;
            if (!hwrite) begin
                case (haddr[7:0])
                    REG_CTRL:      next_st.rdata[CTRL_EN_BIT] = st.en;
                    REG_PTR_LOW:   next_st.rdata[7:0] = st.ptr[7:0];
                    REG_PTR_HIGH:  next_st.rdata[7:0] = st.ptr[15:8];
                    REG_PTR_PAGE:  next_st.rdata[7:0] = st.ptr[23:16];
                    REG_OFS_HIGH:  next_st.rdata[5:0] = st.ofs[13:8];
                    REG_OFS_LOW:   next_st.rdata[7:0] = st.ofs[7:0];
                    REG_GAIN_HIGH: next_st.rdata[5:0] = st.gain[13:8];
                    REG_GAIN_LOW:  next_st.rdata[7:0] = st.gain[7:0];
                    REG_IRQ_STAT:  next_st.rdata[IRQ_W-1:0] = st.irq_stat;
                    REG_IRQ_MASK:  next_st.rdata[IRQ_W-1:0] = st.irq_mask;
                    REG_STATE:     next_st.rdata = {st.wr_ptr, 7'h00, busy};
                    REG_RESULT:    next_st.rdata[11:0] = st.last_res;
                    default:       next_st.rdata = '0;
                endcase
            end
        end

        // engine; hardware sets come after the clears above and so win
        case (st.phase)
            PH_LOAD0: begin
                next_st.phase = PH_LOAD1;
            end
            PH_LOAD1: begin
                next_st.ofs = cal_word;
                cal_addr = 1'b1;
                next_st.phase = PH_LOAD2;
            end
            PH_LOAD2: begin
                next_st.gain = cal_word;
                next_st.irq_stat[IRQ_CAL] = 1'b1;
                next_st.phase = PH_IDLE;
            end
            PH_IDLE: begin
                // cycle 0 only fetches; nothing is converted or written yet
                if (st.en) begin
                    next_st.wr_ptr = st.ptr;
                    next_st.fetch_ptr = st.ptr;
                    next_st.have_id = 1'b0;
                    next_st.have_res = 1'b0;
                    next_st.next_valid = 1'b0;
                    next_st.seen_id = 1'b0;
                    next_st.repeat_id = 1'b0;
                    next_st.stop_seen = 1'b0;
                    next_st.conv_busy = 1'b0;
                    next_st.conv_got = 1'b0;
                    next_st.phase = PH_FETCH;
                end
            end
            PH_START: begin
                if (!st.en) begin
                    next_st.phase = PH_IDLE;
                end else if (!st.have_id && !st.have_res) begin
                    next_st.irq_stat[IRQ_DONE] = 1'b1;
                    next_st.phase = PH_DONE;
                end else begin
                    if (st.have_id) begin
                        next_st.conv.start = 1'b1;
                        next_st.conv.channel = st.cur_id;
                        next_st.conv_busy = 1'b1;
                    end
                    if (st.have_res) begin
                        next_st.phase = PH_WR_HI;
                    end else if (st.stop_seen) begin
                        next_st.phase = PH_WAIT;
                    end else begin
                        next_st.phase = PH_FETCH;
                    end
                end
            end
            PH_WR_HI: begin
                next_st.mem.we = 1'b1;
                next_st.mem.addr = st.wr_ptr;
                next_st.mem.wdata = st.res_pend[15:8];
                next_st.wr_ptr = st.wr_ptr + PTR_STEP;
                next_st.phase = PH_WR_LO;
            end
            PH_WR_LO: begin
                next_st.mem.we = 1'b1;
                next_st.mem.addr = st.wr_ptr;
                next_st.mem.wdata = st.res_pend[7:0];
                next_st.wr_ptr = st.wr_ptr + PTR_STEP;
                next_st.have_res = 1'b0;
                // after the stop code no id slot is read again
                next_st.phase = st.stop_seen ? PH_WAIT : PH_FETCH;
            end
            PH_FETCH: begin
                next_st.mem.re = 1'b1;
                next_st.mem.addr = st.fetch_ptr;
                next_st.fetch_ptr = st.fetch_ptr + ID_STRIDE;
                next_st.phase = PH_FETCH_LAT;
            end
            PH_FETCH_LAT: begin
                // read strobe is on the pins this cycle; data sampled at its end
                if (mem_rdata[7:4] == STOP_ID && st.repeat_id) begin
                    next_st.stop_seen = 1'b1;
                    next_st.next_valid = 1'b0;
                end else begin
                    next_st.next_id = mem_rdata[7:4];
                    next_st.next_valid = 1'b1;
                    next_st.repeat_id = st.seen_id && (mem_rdata[7:4] == st.last_id);
                    next_st.last_id = mem_rdata[7:4];
                    next_st.seen_id = 1'b1;
                end
                next_st.phase = PH_WAIT;
            end
            PH_WAIT: begin
                // the capture cycle closes only when the conversion is in
                if (!st.en) begin
                    next_st.phase = PH_IDLE;
                end else if (!st.conv_busy || st.conv_got) begin
                    if (st.conv_busy) begin
                        next_st.res_pend = {st.conv.channel, st.conv_val};
                        next_st.last_res = st.conv_val;
                        next_st.have_res = 1'b1;
                        next_st.conv_busy = 1'b0;
                        next_st.conv_got = 1'b0;
                    end
                    next_st.cur_id = st.next_id;
                    next_st.have_id = st.next_valid;
                    next_st.next_valid = 1'b0;
                    next_st.phase = PH_START;
                end
            end
            PH_DONE: begin
                if (!st.en) begin
                    next_st.phase = PH_IDLE;
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // bus answers every transfer at once with OKAY
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = st.rdata;
    assign conv_req       = st.conv;
    assign mem_req        = st.mem;
    assign capture_active = st.en;
    assign irq            = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire

// ### acs_capture_assertions.sv
// port checker for the sample capture engine
`timescale 1ns/1ns
`default_nettype none
module acs_chk (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire acs_pkg::acs_conv_req_t conv_req,
    input wire acs_pkg::acs_mem_req_t  mem_req,
    input wire acs_pkg::acs_mem_req_t  core_req,
    input wire logic                   capture_active
);
    import acs_pkg::*;
    logic [23:0] last_fetch;
    logic [23:0] last_wr;
    logic        had_fetch;
    logic        had_wr;
    logic [1:0]  starts;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // engine traffic history, forgotten whenever capture is off
    always_ff @(posedge core_clk) begin
        if (rst || !capture_active) begin
            had_fetch <= 1'b0;
            had_wr <= 1'b0;
            starts <= 2'd0;
        end else begin
            if (mem_req.re) had_fetch <= 1'b1;
            if (mem_req.re) last_fetch <= mem_req.addr;
            if (mem_req.we) had_wr <= 1'b1;
            if (mem_req.we) last_wr <= mem_req.addr;
            if (conv_req.start && starts != 2'd3) starts <= starts + 2'd1;
        end
    end
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("conversion start longer than one cycle");
    a_idle_quiet: assert property (!capture_active && !$past(capture_active) |-> !conv_req.start)
        else $error("conversion started with capture off");
    a_fetch_pulse: assert property (capture_active && mem_req.re |=> !mem_req.re)
        else $error("id fetch strobe stuck");
    a_fetch_step: assert property (capture_active && mem_req.re && had_fetch
        |-> mem_req.addr == last_fetch + ID_STRIDE)
        else $error("id fetch not two locations on");
    a_write_step: assert property (capture_active && mem_req.we && had_wr
        |-> mem_req.addr == last_wr + PTR_STEP)
        else $error("write pointer did not step by one");
    a_write_pair: assert property (capture_active && $rose(mem_req.we)
        |=> mem_req.we ##1 !mem_req.we)
        else $error("result not written as two bytes");
    a_first_result: assert property (capture_active && mem_req.we && !had_wr
        |-> starts == 2'd2)
        else $error("first result written in wrong capture cycle");
    a_core_pass: assert property (!capture_active && !$past(capture_active)
        |-> mem_req == $past(core_req))
        else $error("core request not passed with capture off");
endmodule
bind acs_capture acs_chk u_chk (.core_clk(core_clk), .rst(rst), .conv_req(conv_req),
    .mem_req(mem_req), .core_req(core_req), .capture_active(capture_active));
`default_nettype wire

// ### acs_ext_model.sv
// external sram and converter as seen by the engine
`timescale 1ns/1ns
`default_nettype none
module acs_ext_model (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [3:0]             lat,
    input  wire acs_pkg::acs_conv_req_t conv_req,
    output acs_pkg::acs_conv_rsp_t      conv_rsp,
    input  wire acs_pkg::acs_mem_req_t  mem_req,
    output logic [7:0]                  mem_rdata
);
    import acs_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] noise;
    logic [3:0] cnt;
    logic [3:0] ch;
    // byte writes land at the end of the strobe cycle; plain always so the bench may preload
    always @(posedge core_clk) begin
        noise <= rst ? 8'h00 : noise + 8'h3b;
        if (mem_req.we) mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    // a released bus shows a moving pattern, never the last byte
    assign mem_rdata = mem_req.re ? mem[mem_req.addr[7:0]] : noise;
    // result comes lat cycles after start, channel coded in its top nibble
    always @(posedge core_clk) begin
        conv_rsp.done <= 1'b0;
        if (rst) begin
            cnt <= 4'h0;
            conv_rsp.result <= 12'h000;
        end else if (conv_req.start) begin
            cnt <= lat;
            ch <= conv_req.channel;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            conv_rsp.done <= (cnt == 4'h1);
            conv_rsp.result <= (cnt == 4'h1) ? {ch, 8'h4c} : ~conv_rsp.result;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the sample capture engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import acs_pkg::*;
    localparam logic [13:0] OFS_F  = 14'h2abc;  // arbitrary factory trim
    localparam logic [13:0] GAIN_F = 14'h1d37;  // arbitrary factory trim
    logic          core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, capture_active, irq;
    logic [31:0]   haddr, hwdata, hrdata, q;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [3:0]    lat;
    logic [7:0]    mem_rdata;
    acs_conv_req_t conv_req;
    acs_conv_rsp_t conv_rsp;
    acs_mem_req_t  mem_req, core_req;
    int            fail_count, checks;
    assign hready = hreadyout;
    acs_capture #(.OFS_FACTORY(OFS_F), .GAIN_FACTORY(GAIN_F)) dut (.core_clk(core_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .conv_req(conv_req), .conv_rsp(conv_rsp),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .core_req(core_req),
        .capture_active(capture_active), .irq(irq));
    acs_ext_model u_ext (.core_clk(core_clk), .rst(rst), .lat(lat), .conv_req(conv_req),
        .conv_rsp(conv_rsp), .mem_req(mem_req), .mem_rdata(mem_rdata));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // irq derives from registers, so give it time to follow a write
    task automatic settle;
        repeat (2) @(posedge core_clk);
    endtask
    // expected trim arithmetic, worked out independently
    function automatic logic [31:0] cal(input logic [11:0] raw, input int o, input int g);
        int y;
        int k;
        y = int'(raw) - ((o - int'(CAL_MID)) >>> 5);
        k = g - int'(CAL_MID);
        if (k > GAIN_SPAN) k = GAIN_SPAN;
        if (k < -GAIN_SPAN) k = -GAIN_SPAN;
        y = y + ((y * k) >>> 18);
        if (y < 0) y = 0;
        if (y > RES_MAX) y = RES_MAX;
        return 32'(y);
    endfunction
    function automatic logic [31:0] m(input logic [23:0] p, input int i);
        return {24'h0, u_ext.mem[8'(int'(p[7:0]) + i)]};
    endfunction
    task automatic t_trim;
        bus(0, REG_OFS_HIGH, 0);
        chk(q, {26'h0, OFS_F[13:8]});
        bus(0, REG_OFS_LOW, 0);
        chk(q, {24'h0, OFS_F[7:0]});
        bus(0, REG_GAIN_HIGH, 0);
        chk(q, {26'h0, GAIN_F[13:8]});
        bus(0, REG_GAIN_LOW, 0);
        chk(q, {24'h0, GAIN_F[7:0]});
        bus(1, REG_OFS_HIGH, 32'hff);
        bus(0, REG_OFS_HIGH, 0);
        chk(q, 32'h3f);
        bus(1, 8'h30, 32'h5);
        bus(0, 8'h30, 0);
        chk(q, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test trim done");
    endtask
    task automatic t_irq;
        bus(0, REG_IRQ_STAT, 0);
        chk(q, 32'h2);
        chk({31'h0, irq}, 32'h0);
        bus(1, REG_IRQ_MASK, 32'h2);
        settle;
        chk({31'h0, irq}, 32'h1);
        bus(1, REG_IRQ_STAT, 32'h2);
        settle;
        chk({31'h0, irq}, 32'h0);
        bus(0, REG_IRQ_STAT, 0);
        chk(q, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_core;
        core_req <= '{24'h0000f0, 8'h77, 1'b1, 1'b0};
        @(posedge core_clk);
        core_req <= '0;
        repeat (3) @(posedge core_clk);
        chk(m(24'h0, 8'hf0), 32'h77);
        $display("test core port done");
    endtask
    // one full capture: ids packed as nibbles, n results expected
    task automatic run(input logic [23:0] p, input logic [15:0] ids, input int n,
                       input logic [13:0] o, input logic [13:0] g);
        logic [3:0]  v;
        logic [31:0] e;
        for (int i = 0; i < 8; i++)
            u_ext.mem[8'(int'(p[7:0]) + i)] = (i % 2 == 0 && i <= 2 * n) ?
                {ids[15 - 2 * i -: 4], 4'h0} : 8'hee;
        bus(1, REG_OFS_HIGH, {26'h0, o[13:8]});
        bus(1, REG_OFS_LOW, {24'h0, o[7:0]});
        bus(1, REG_GAIN_HIGH, {26'h0, g[13:8]});
        bus(1, REG_GAIN_LOW, {24'h0, g[7:0]});
        bus(1, REG_PTR_LOW, {24'h0, p[7:0]});
        bus(1, REG_PTR_HIGH, {24'h0, p[15:8]});
        bus(1, REG_PTR_PAGE, {24'h0, p[23:16]});
        bus(1, REG_IRQ_MASK, 32'h1);
        bus(1, REG_CTRL, 32'h40);
        core_req <= '{24'h0000f0, 8'h11, 1'b1, 1'b0};
        @(posedge core_clk);
        core_req <= '0;
        chk({31'h0, capture_active}, 32'h1);
        for (int w = 0; w < 3000 && irq !== 1'b1; w++) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        bus(0, REG_IRQ_STAT, 0);
        chk(q & 32'h1, 32'h1);
        bus(0, REG_STATE, 0);
        chk(q, {p + 24'(2 * n), 8'h00});
        for (int i = 0; i < n; i++) begin
            v = ids[15 - 4 * i -: 4];
            e = cal({v, 8'h4c}, int'(o), int'(g));
            chk(m(p, 2 * i), {24'h0, v, e[11:8]});
            chk(m(p, 2 * i + 1), {24'h0, e[7:0]});
        end
        chk(m(p, 2 * n), {24'h0, ids[15 - 4 * n -: 4], 4'h0});
        chk(m(p, 2 * n + 1), 32'hee);
        chk(m(24'h0, 8'hf0), 32'h77);
        bus(0, REG_RESULT, 0);
        chk(q, {20'h0, e[11:0]});
        bus(1, REG_CTRL, 32'h0);
        bus(1, REG_IRQ_STAT, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, capture_active}, 32'h0);
    endtask
    task automatic t_cap_plain;
        lat <= 4'd2;
        run(24'h012340, 16'h599f, 3, CAL_MID, CAL_MID);
        $display("test plain capture done");
    endtask
    task automatic t_cap_cal;
        lat <= 4'd9;
        run(24'h000080, 16'h33f0, 2, 14'h2040, 14'h3000);
        $display("test calibrated capture done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        close_out;
    end
    // main sequence
    initial begin
        {rst, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        rst = 1'b1;
        hsize = 3'b010;
        lat = 4'd2;
        core_req = '0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        t_trim;
        t_irq;
        t_core;
        t_cap_plain;
        t_cap_cal;
        close_out;
    end
endmodule
`default_nettype wire
